// *** hdl/iowd_top.sv ***
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Timeout between ten and twenty seconds unserviced
// RQ2 - Host services watchdog every scan
// RQ3 - Fault switches the output circuit
// RQ4 - Switch one: channel eight I/O or watchdog
// RQ5 - Switch two: fault polarity of output
// RQ6 - Switch three: relay normally open or closed
// RQ7 - Switch four: solid-state or mechanical relay
// RQ8 - Host enables channel eight as output
// RQ9 - Mode choices: disabled, alarm, processor watchdog
// RQ10 - Readable milliseconds since last service
// RQ11 - Disabled mode: elapsed keeps counting up
// RQ12 - Timeout cleared by reset or disable
// RQ13 - Virtual channels act as software watchdogs
// RQ14 - Service zeroes counter; millisecond tick
module iowd_top
    import iowd_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int TIMEOUT_MS = TMO_MS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [SYNC_W-1:0] cfg_switch_raw,
    output logic [NCH-2:0] general_io_use_out,
    output logic ssr_drive,
    output logic mech_relay_coil,
    output logic irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_have;
        logic w_have;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [NCH-1:0] gpio;
        logic [2*NCH-1:0] mode;
        logic [NCH-1:0] virt;
        logic [NCH-1:0] tmo;
        logic [NCH-1:0] ist;
        logic [NCH-1:0] imask;
        logic [NCH-1:0][31:0] elapsed_since_service_ms;
        logic [NCH-2:0] gout;
        logic ssr;
        logic coil;
        logic irq;
    } iowd_st_type;

    localparam iowd_st_type ST_RST = '{
        gpio: GPIO_RST, mode: MODE_RST, virt: VIRT_RST, imask: MASK_RST,
        default: '0};

    iowd_st_type st_ff;
    iowd_st_type nxt_st;
    iowd_sw_type sw;
    logic [SYNC_W-1:0] sw_q;
    logic tick;
    logic wr_go;
    logic fn;
    logic [31:0] wv;
    logic [NCH-1:0] svc;
    logic [NCH-1:0] clr;
    logic [NCH-1:0] ev;
    logic [NCH-1:0] armed;

    iowd_pin_sync #(.W(SYNC_W)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_raw(cfg_switch_raw),
        .pin_q(sw_q)
    );

    // Free-running tick: first tick after service may come early
    iowd_tick_div #(.DIV(TICK_CYCLES)) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    assign sw = sw_q;

    function automatic logic [31:0] iowd_merge(input logic [31:0] old,
            input logic [31:0] d, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b+:8] = d[8*b+:8];
            end
        end
        return r;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        svc = '0;
        clr = '0;
        ev = '0;
        armed = '0;
        wv = '0;
        fn = 1'b0;
        wr_go = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (wr_go) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
            case (st_ff.awaddr)
                OFS_GPIO: begin
                    wv = iowd_merge({24'h0, st_ff.gpio}, st_ff.wdata,
                        st_ff.wstrb);
                    nxt_st.gpio = wv[NCH-1:0];
                end
                OFS_MODE: begin
                    wv = iowd_merge({16'h0, st_ff.mode}, st_ff.wdata,
                        st_ff.wstrb);
                    nxt_st.mode = wv[2*NCH-1:0];
                end
                OFS_VIRT: begin
                    wv = iowd_merge({24'h0, st_ff.virt}, st_ff.wdata,
                        st_ff.wstrb);
                    nxt_st.virt = wv[NCH-1:0];
                end
                OFS_SERVICE: begin
                    svc = st_ff.wdata[NCH-1:0] & {NCH{st_ff.wstrb[0]}};
                end
                OFS_IRQ_STAT: begin
                    clr = st_ff.wdata[NCH-1:0] & {NCH{st_ff.wstrb[0]}};
                end
                OFS_IRQ_MASK: begin
                    wv = iowd_merge({24'h0, st_ff.imask}, st_ff.wdata,
                        st_ff.wstrb);
                    nxt_st.imask = wv[NCH-1:0];
                end
                default: begin
                    nxt_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
        nxt_st.wready = !nxt_st.w_have && !nxt_st.bvalid;

        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = RESP_OKAY;
            nxt_st.rdata = '0;
            if (s_axi_araddr >= OFS_ELAPSED &&
                    s_axi_araddr < OFS_ELAPSED_END &&
                    s_axi_araddr[1:0] == 2'h0) begin
                nxt_st.rdata =
                    st_ff.elapsed_since_service_ms[s_axi_araddr[4:2]]; // RQ10
            end else begin
                case (s_axi_araddr)
                    OFS_GPIO: nxt_st.rdata[NCH-1:0] = st_ff.gpio;
                    OFS_MODE: nxt_st.rdata[2*NCH-1:0] = st_ff.mode;
                    OFS_VIRT: nxt_st.rdata[NCH-1:0] = st_ff.virt;
                    OFS_SERVICE: nxt_st.rdata = '0;
                    OFS_STATUS: begin
                        nxt_st.rdata[NCH-1:0] = st_ff.tmo;
                        nxt_st.rdata[NCH+:SYNC_W] = sw;
                    end
                    OFS_IRQ_STAT: nxt_st.rdata[NCH-1:0] = st_ff.ist;
                    OFS_IRQ_MASK: nxt_st.rdata[NCH-1:0] = st_ff.imask;
                    default: nxt_st.rresp = RESP_SLVERR;
                endcase
            end
        end
        nxt_st.arready = !nxt_st.rvalid;

        for (int i = 0; i < NCH; i++) begin
            // Non-watchdog channels need the virtual flag
            armed[i] = iowd_is_wd(st_ff.mode[2*i+:2]) &&
                (st_ff.virt[i] || (i == WD_CH && sw.use_wd)); // RQ13 RQ9
            // Disabled mode ignores service so the count runs on
            if (svc[i] && iowd_is_wd(st_ff.mode[2*i+:2])) begin
                nxt_st.elapsed_since_service_ms[i] = '0; // RQ14
            end else if (tick && st_ff.elapsed_since_service_ms[i] != '1) begin
                nxt_st.elapsed_since_service_ms[i] =
                    st_ff.elapsed_since_service_ms[i] + 32'h1; // RQ10 RQ11
            end
            if (!iowd_is_wd(nxt_st.mode[2*i+:2])) begin
                nxt_st.tmo[i] = 1'b0; // RQ12
            end else if (armed[i] && st_ff.elapsed_since_service_ms[i] >=
                    32'(TIMEOUT_MS)) begin
                nxt_st.tmo[i] = 1'b1; // RQ1
                ev[i] = !st_ff.tmo[i];
            end
        end
        // Set wins over a same-cycle clear
        nxt_st.ist = (st_ff.ist & ~clr) | ev;
        nxt_st.irq = |(nxt_st.ist & nxt_st.imask);

        if (sw.use_wd) begin
            fn = sw.fault_on ? nxt_st.tmo[WD_CH] : !nxt_st.tmo[WD_CH]; // RQ3 RQ5
        end else begin
            fn = nxt_st.gpio[WD_CH]; // RQ4
        end
        nxt_st.ssr = !sw.mech && fn; // RQ7
        nxt_st.coil = sw.mech && (fn ^ sw.nc); // RQ6 RQ7
        nxt_st.gout = nxt_st.gpio[NCH-2:0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rdata = st_ff.rdata;
    assign general_io_use_out = st_ff.gout;
    assign ssr_drive = st_ff.ssr;
    assign mech_relay_coil = st_ff.coil;
    assign irq = st_ff.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        a_tmo_not_early: assert property ( // RQ1
            $rose(st_ff.tmo[g]) |->
                $past(st_ff.elapsed_since_service_ms[g]) >= TIMEOUT_MS)
            else $error("timeout before window");
        a_tmo_not_late: assert property ( // RQ1 RQ13
            armed[g] && iowd_is_wd(nxt_st.mode[2*g+:2]) &&
                st_ff.elapsed_since_service_ms[g] >= TIMEOUT_MS
                |=> st_ff.tmo[g])
            else $error("timeout missed");
        a_disable_clears: assert property ( // RQ12 RQ9
            !iowd_is_wd(st_ff.mode[2*g+:2]) |-> !st_ff.tmo[g])
            else $error("timeout held while disabled");
        a_elapsed_counts: assert property ( // RQ10 RQ11
            tick && !svc[g] && st_ff.elapsed_since_service_ms[g] != '1
                |=> st_ff.elapsed_since_service_ms[g] ==
                $past(st_ff.elapsed_since_service_ms[g]) + 32'h1)
            else $error("elapsed count stalled");
        a_service_zero: assert property ( // RQ14
            svc[g] && iowd_is_wd(st_ff.mode[2*g+:2]) |=>
                st_ff.elapsed_since_service_ms[g] == 32'h0)
            else $error("service did not zero count");
    end

    a_fault_polarity: assert property ( // RQ3 RQ5
        $past(sw.use_wd && !sw.mech) |->
            st_ff.ssr == (st_ff.tmo[WD_CH] ~^ $past(sw.fault_on)))
        else $error("watchdog output polarity wrong");
    a_io_passthru: assert property ( // RQ4
        $past(!sw.use_wd && !sw.mech) |-> st_ff.ssr == st_ff.gpio[WD_CH])
        else $error("channel eight not plain output");
    a_relay_sense: assert property ( // RQ6
        $past(sw.mech && !sw.use_wd) |->
            st_ff.coil == (st_ff.gpio[WD_CH] ^ $past(sw.nc)))
        else $error("relay contact sense wrong");
    a_relay_route: assert property ( // RQ7
        $past(sw.mech) |-> !st_ff.ssr)
        else $error("relay routing wrong");
    a_coil_idle: assert property ( // RQ7
        $past(!sw.mech) |-> !st_ff.coil)
        else $error("coil driven with solid-state route");
    a_irq_level: assert property (
        |(st_ff.ist & st_ff.imask) && $stable(st_ff.ist) |-> st_ff.irq)
        else $error("interrupt not raised");
endmodule

// *** hdl/iowd_pkg.sv ***
package iowd_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int TICK_CYC = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S = 1000;
    localparam int TMO_MIN_S = 10;
    localparam int TMO_MAX_S = 20;
    // Midpoint keeps margin at both ends despite tick phase
    localparam int TMO_MS = (TMO_MIN_S + TMO_MAX_S) * MS_PER_S / 2;
    localparam int NCH = 8;
    localparam int WD_CH = 7;
    localparam int ADDR_W = 8;
    localparam int SYNC_W = 4;

    localparam logic [1:0] MODE_DIS = 2'h1;
    localparam logic [1:0] MODE_ALARM = 2'h2;
    localparam logic [1:0] MODE_CPU = 2'h3;

    localparam logic [ADDR_W-1:0] OFS_GPIO = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_VIRT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_SERVICE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_ELAPSED = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ELAPSED_END = 8'h40;

    localparam logic [NCH-1:0] GPIO_RST = 8'h00;
    localparam logic [2*NCH-1:0] MODE_RST = 16'h5555;
    localparam logic [NCH-1:0] VIRT_RST = 8'h00;
    localparam logic [NCH-1:0] MASK_RST = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic mech;
        logic nc;
        logic fault_on;
        logic use_wd;
    } iowd_sw_type;

    function automatic logic iowd_is_wd(input logic [1:0] m);
        return (m == MODE_ALARM) || (m == MODE_CPU);
    endfunction
endpackage

// *** hdl/iowd_pin_sync.sv ***
`timescale 1ns/1ps
module iowd_pin_sync
    import iowd_pkg::*;
#(
    parameter int W = SYNC_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] pin_raw,
    output logic [W-1:0] pin_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } iowd_sync_type;

    iowd_sync_type st_ff;
    iowd_sync_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // Change accepted only once two stages agree
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_q = st_ff.q;
endmodule

// *** hdl/iowd_tick_div.sv ***
`timescale 1ns/1ps
module iowd_tick_div
    import iowd_pkg::*;
#(
    parameter int DIV = TICK_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } iowd_div_type;

    iowd_div_type st_ff;
    iowd_div_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt >= 32'(DIV - 1)) begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 32'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;
endmodule

// *** testbench/iowd_host_model.sv ***
`timescale 1ns/1ps
module iowd_host_model
    import iowd_pkg::*;
(
    input wire logic aclk,
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic hung
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, hung} = '0;
        wstrb = 4'hf;
    end

    // Caller resumes right after an edge; one write in flight
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw;
        logic w;
        int n;
        aw = 1'b0;
        w = 1'b0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (aw && w && bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
            aw = aw | awready;
            w = w | wready;
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        if (n == 40) hung <= 1'b1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        logic t;
        int n;
        t = 1'b0;
        d = '0;
        r = 2'h3;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (t && rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            t = t | arready;
            if (t) arvalid <= 1'b0;
        end
        if (n == 40) hung <= 1'b1;
    endtask

    // One scan of the firmware: kick the channels set in m
    task automatic scan(input logic [7:0] m);
        logic [1:0] r;
        wr(OFS_SERVICE, {24'h0, m}, r);
    endtask
endmodule

// *** testbench/iowd_top_tb_top.sv ***
`timescale 1ns/1ps
module iowd_top_tb_top
    import iowd_pkg::*;
;
    // Short counts keep the run brief; expectations scale with them
    localparam int TK = 4;
    localparam int TO = 5;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, hung, ssr, coil, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v, e1, mode_v;
    logic [3:0] wstrb, sw;
    logic [1:0] bresp, rresp, r;
    logic [NCH-2:0] gio;
    int num_errors, n_tests;

    initial aclk = 1'b0;
    always #2 aclk = ~aclk;

    iowd_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .hung(hung));

    iowd_top #(.TICK_CYCLES(TK), .TIMEOUT_MS(TO)) dut (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cfg_switch_raw(sw), .general_io_use_out(gio), .ssr_drive(ssr),
        .mech_relay_coil(coil), .irq(irq));

    task automatic report_and_stop;
        if (num_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge aclk) begin
        if (hung === 1'b1) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        host.rd(a, v, r);
        chk(nm, e, v);
        chk("rresp", 32'h0, {30'h0, r});
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        host.wr(a, d, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask

    // Pins pass a synchroniser, so allow a few edges to settle
    task automatic setsw(input logic [3:0] s);
        @(posedge aclk);
        sw <= s;
        idle(8);
    endtask

    task automatic setmode(input int ch, input logic [1:0] m);
        mode_v[2*ch +: 2] = m;
        wreg(OFS_MODE, mode_v);
    endtask

    task automatic t_reset;
        rchk("gpio", OFS_GPIO, 32'h0);
        rchk("mode", OFS_MODE, {16'h0, MODE_RST});
        rchk("mask", OFS_IRQ_MASK, 32'h0);
        host.rd(8'h40, v, r);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, v);
    endtask

    task automatic t_switches;
        wreg(OFS_GPIO, 32'ha5);
        setsw(4'h0);
        chk("gio", 32'h25, {25'h0, gio});
        chk("ssr ch8 io", 32'h1, {31'h0, ssr});
        chk("coil off", 32'h0, {31'h0, coil});
        setsw(4'h8);
        chk("ssr idle", 32'h0, {31'h0, ssr});
        chk("coil no", 32'h1, {31'h0, coil});
        setsw(4'hc);
        chk("coil nc", 32'h0, {31'h0, coil});
        wreg(OFS_GPIO, 32'h25);
        idle(2);
        chk("coil nc rest", 32'h1, {31'h0, coil});
        rchk("status sw", OFS_STATUS, 32'hc00);
    endtask

    task automatic t_cpu_wd;
        // Arm only after a kick: the count ran on while disabled
        wreg(OFS_IRQ_MASK, 32'h80);
        setmode(7, MODE_CPU);
        host.scan(8'h80);
        setsw(4'h3);
        repeat (6) begin
            host.scan(8'h80);
            idle(8);
        end
        host.scan(8'h80);
        idle(6);
        rchk("no early trip", OFS_STATUS, 32'h300);
        chk("ssr healthy", 32'h0, {31'h0, ssr});
        host.rd(OFS_ELAPSED + 8'h1c, v, r);
        chk("elapsed resp", 32'h0, {30'h0, r});
        chk("elapsed small", 32'h1, {31'h0, v < TO});
        idle(TO * TK + 12);
        rchk("tripped", OFS_STATUS, 32'h380);
        chk("ssr fault", 32'h1, {31'h0, ssr});
        chk("irq", 32'h1, {31'h0, irq});
        rchk("irq stat", OFS_IRQ_STAT, 32'h80);
        setsw(4'h1);
        chk("ssr fault low", 32'h0, {31'h0, ssr});
        host.scan(8'h80);
        rchk("service keeps", OFS_STATUS, 32'h180);
        wreg(OFS_IRQ_MASK, 32'h0);
        idle(2);
        chk("irq masked", 32'h0, {31'h0, irq});
        wreg(OFS_IRQ_MASK, 32'h80);
        wreg(OFS_IRQ_STAT, 32'h80);
        idle(2);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rchk("stat cleared", OFS_IRQ_STAT, 32'h0);
        setmode(7, MODE_DIS);
        rchk("disable clears", OFS_STATUS, 32'h100);
    endtask

    task automatic t_elapsed;
        host.scan(8'h01);
        host.rd(OFS_ELAPSED, e1, r);
        idle(20);
        host.rd(OFS_ELAPSED, v, r);
        chk("disabled ignores kick", 32'h1, {31'h0, e1 > 10});
        chk("disabled grows", 32'h1, {31'h0, v - e1 >= 5});
        setmode(0, MODE_ALARM);
        host.scan(8'h01);
        host.rd(OFS_ELAPSED, v, r);
        chk("kick zeroes resp", 32'h0, {30'h0, r});
        chk("kick small", 32'h1, {31'h0, v < 3});
    endtask

    task automatic t_virtual;
        setmode(0, MODE_DIS);
        wreg(OFS_VIRT, 32'h1c);
        setmode(2, MODE_ALARM);
        setmode(4, MODE_CPU);
        idle(TO * TK + 12);
        rchk("virtual trips", OFS_STATUS, 32'h114);
    endtask

    task automatic t_power_cycle;
        @(posedge aclk);
        aresetn <= 1'b0;
        idle(16);
        aresetn <= 1'b1;
        idle(8);
        rchk("reset clears", OFS_STATUS, 32'h100);
    endtask

    initial begin
        aresetn = 1'b0;
        sw = 4'h0;
        num_errors = 0;
        n_tests = 0;
        mode_v = {16'h0, MODE_RST};
        idle(16);
        aresetn <= 1'b1;
        idle(4);
        t_reset();
        t_switches();
        t_cpu_wd();
        t_elapsed();
        t_virtual();
        t_power_cycle();
        report_and_stop();
    end
endmodule
